// ---- rtl/cth_pkg.sv ----
// Purpose: Shared constants, register map and carrier types of the touch tuning logic.
// Assumes: 50 MHz system clock, three sensing channels, 12-bit sample counts.
// Notes: Timing figures are kept in their own units; cycle counts derive from them.
package cth_pkg;
	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int NUM_CH = 3;
	localparam int CNT_W = 12;
	localparam int COMP_W = 6;
	localparam int MULT_W = 4;
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int RESEED_DELAY_MS = 250;
	localparam int INHIBIT_TIME_S = 10;
	localparam int INHIBIT_MS = INHIBIT_TIME_S * MS_PER_S;
	localparam int THR_SHIFT = 8;
	localparam int TGT_SHIFT = 3;
	localparam int RELIMIT_SHIFT = 3;
	localparam int EXT_BASE_SHIFT = 4;
	localparam int BASE_SHIFT = 3;
	localparam logic [7:0] THR_MIN = 8'h01;
	localparam logic [7:0] THR_MAX = 8'hfe;
	localparam logic [CNT_W-1:0] DYN_WINDOW = 12'h010;
	localparam logic [CNT_W-1:0] TUNE_TOL = 12'h008;
	localparam logic [1:0] STRAP_READY = 2'h2;
	localparam logic [1:0] STRAP_DONE = 2'h3;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SYSTEM_FLAGS = 8'hc0;
	localparam logic [7:0] ADDR_CTRL = 8'hc1;
	localparam logic [7:0] ADDR_CTRL2 = 8'hc2;
	localparam logic [7:0] ADDR_HYST_CHANS = 8'hc3;
	localparam logic [7:0] ADDR_TARGET = 8'hc4;
	localparam logic [7:0] ADDR_HYST_OUT = 8'hc5;
	localparam logic [7:0] ADDR_HYST_TOUCH = 8'hc6;
	localparam logic [7:0] ADDR_STATUS = 8'hc7;
	localparam logic [7:0] ADDR_BASE0 = 8'hc8;
	localparam logic [7:0] ADDR_BASE2 = 8'hca;
	localparam logic [7:0] ADDR_TOUCH_SET0 = 8'hcb;
	localparam logic [7:0] ADDR_PROX_SET0 = 8'hce;

	// Control register bits.
	localparam int CTRL_TDIS = 0;
	localparam int CTRL_MGS = 1;
	localparam int CTRL_EXTB = 2;
	localparam int CTRL_RETUNE = 3;
	localparam int CTRL_FAST = 4;
	localparam int CTRL_OOT = 5;
	localparam int CTRL_BLK = 6;
	localparam int CTRL_PROJ = 7;
	// Second control register bits.
	localparam int CTRL2_INH_DIS = 2;
	localparam int CTRL2_RSD_DIS = 3;
	localparam int CTRL2_TO_DIS = 4;

	// Reset values and tuning limits.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] HYST_RST = 8'h07;
	localparam logic [7:0] TARGET_RST = 8'h80;
	localparam logic [7:0] BASE_RST = 8'h00;
	localparam logic [7:0] TOUCH_SET_RST = 8'h1e;
	localparam logic [7:0] PROX_SET_RST = 8'h08;
	localparam logic [COMP_W-1:0] COMP_MAX = 6'h3f;
	localparam logic [MULT_W-1:0] MULT_MAX = 4'hf;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [CNT_W-1:0] count;
	} cth_sample_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} cth_reg_req_t;

	typedef struct packed {
		logic [1:0] factSync;
		logic [1:0] strapCnt;
		logic inSetup;
		logic readyOe;
		logic [15:0] tickCnt;
		logic [15:0] winMs;
		logic [15:0] scanCnt;
		logic convStart;
		logic [1:0] convChan;
		logic [7:0] ctrl;
		logic [7:0] ctrl2;
		logic [7:0] hystMask;
		logic [7:0] target;
		logic [NUM_CH-1:0][7:0] base;
		logic [NUM_CH-1:0][7:0] touchSet;
		logic [NUM_CH-1:0][7:0] proxSet;
		logic busy;
		logic [NUM_CH-1:0] tuneDone;
		logic [NUM_CH-1:0] multDone;
		logic [NUM_CH-1:0][COMP_W-1:0] comp;
		logic [NUM_CH-1:0][MULT_W-1:0] mult;
		logic [NUM_CH-1:0][7:0] multOut;
		logic [NUM_CH-1:0][CNT_W-1:0] baseline;
		logic [NUM_CH-1:0][CNT_W-1:0] entryBase;
		logic [NUM_CH-1:0][CNT_W-1:0] dynThr;
		logic [NUM_CH-1:0] dynValid;
		logic [NUM_CH-1:0] touchState;
		logic [NUM_CH-1:0] pendTouch;
		logic [NUM_CH-1:0] reseedPend;
		logic [NUM_CH-1:0] touchBit;
		logic [NUM_CH-1:0] proxBit;
		logic [NUM_CH-1:0] hystOut;
		logic [NUM_CH-1:0] touchRep;
		logic [NUM_CH-1:0][7:0] reseedMs;
		logic [NUM_CH-1:0][13:0] inhibitMs;
		logic [7:0] rdData;
	} cth_state_t;

	// Clamp a threshold setting into its legal range.
	function automatic logic [7:0] thrClamp(input logic [7:0] v);
		thrClamp = (v < THR_MIN) ? THR_MIN : ((v > THR_MAX) ? THR_MAX : v);
	endfunction : thrClamp
endpackage : cth_pkg

// ---- rtl/cth_tuning_logic.sv ----
// Purpose: Decision, hysteresis and gain tuning logic for a three-channel touch sensor.
// Assumes: Samples and register accesses arrive already decoded, on the system clock.
// Notes: Raising compensation is taken to raise the sample count.
`timescale 1ns/10ps

// Behaviour
// - Touch threshold is setting/256 times baseline
// - Auto tuning on after reset, disable bit stops
// - Busy flag high throughout any tuning event
// - Tune compensation toward target register times eight
// - Auto mode picks multiplier toward selected base
// - Manual mode uses base registers, still tunes compensation
// - Retune when count strays beyond target/8
// - Retune request bit self-clears once tuning starts
// - Report hysteresis outputs and touch state separately
// - Hysteresis output on proximity, or touch if selected
// - Channel 1 touch blocks other channel outputs
// - Release at fraction of larger threshold, clear output
// - Dynamic threshold once baseline within 16 counts
// - Reseed baseline on touch entry, delayed 250ms
// - Inhibit retune 10s after release unless disabled
// - Fixed scan period; fast scan minimal, filter bypassed
// - Fast scan enters touch state on first detection
// - Ready low during setup; STOP starts conversions
// - Setup window times out, occurs once only
// - Sensing mode changes only in setup or strap
// - Self below, projected above baseline by threshold
// - Per channel hysteresis or direct, default hysteresis
module cth_tuning_logic #(
	parameter int TICK_CYCLES = cth_pkg::CLK_HZ / cth_pkg::MS_PER_S,
	parameter int WINDOW_TIMEOUT_MS = 20,
	parameter int SCAN_PERIOD_CYCLES = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire cth_pkg::cth_sample_t sample,
	input wire cth_pkg::cth_reg_req_t regReq,
	input wire logic busStop,
	input wire logic factoryOption,
	output logic [7:0] regRdData,
	output logic readyOut,
	output logic readyOe,
	output logic convStart,
	output logic [1:0] convChan,
	output logic filterBypass,
	output logic projMode,
	output logic tuneBusy,
	output logic [cth_pkg::NUM_CH-1:0][cth_pkg::COMP_W-1:0] compOut,
	output logic [cth_pkg::NUM_CH-1:0][7:0] multOut,
	output logic [cth_pkg::NUM_CH-1:0] hystOutput,
	output logic [cth_pkg::NUM_CH-1:0] hystTouchState
);
	import cth_pkg::*;

	// ----------------------------------------------------------------
	// State and scratch
	// ----------------------------------------------------------------
	cth_state_t s_q;
	cth_state_t s_d;
	logic [NUM_CH-1:0][CNT_W-1:0] touchThr;
	logic [19:0] prod;
	logic tick, startTune, blk, tDet, pDet, self;
	logic [1:0] c;
	logic [CNT_W-1:0] cnt, bl, thr, diff, mx, rel, goal;
	logic [CNT_W:0] tgt;

	// Release threshold as a fraction of the larger threshold.
	function automatic logic [CNT_W-1:0] relFrac(input logic [CNT_W-1:0] m, input logic [1:0] sel);
		unique case (sel)
			2'h0: relFrac = m >> 2;
			2'h1: relFrac = m >> 1;
			2'h2: relFrac = m - (m >> 2);
			2'h3: relFrac = m - (m >> 3);
		endcase
	endfunction : relFrac

	// Baseline value after a touch-entry reseed.
	function automatic logic [CNT_W-1:0] reseedVal(input logic [CNT_W-1:0] b,
		input logic [CNT_W-1:0] t, input logic proj);
		reseedVal = proj ? CNT_W'(b + t) : CNT_W'(b - t);
	endfunction : reseedVal

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		prod = '0;
		tDet = 1'b0;
		pDet = 1'b0;
		cnt = sample.count;
		c = sample.chan;
		bl = '0;
		thr = '0;
		diff = '0;
		mx = '0;
		rel = '0;
		goal = '0;
		startTune = 1'b0;
		self = !s_q.ctrl[CTRL_PROJ];
		tgt = {2'b00, s_q.target, 3'b000};
		s_d.convStart = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			prod = 20'(thrClamp(s_q.touchSet[i])) * 20'(s_q.baseline[i]);
			touchThr[i] = prod[19:THR_SHIFT];
		end
		// Strap capture for the sensing mode, after two sync stages.
		s_d.factSync = {s_q.factSync[0], factoryOption};
		if (s_q.strapCnt != STRAP_DONE) begin
			s_d.strapCnt = s_q.strapCnt + 2'h1;
			if (s_q.strapCnt == STRAP_READY) begin
				s_d.ctrl[CTRL_PROJ] = s_q.factSync[1];
			end
		end
		// Millisecond enable.
		tick = (s_q.tickCnt == 16'(TICK_CYCLES - 1));
		s_d.tickCnt = tick ? 16'h0000 : s_q.tickCnt + 16'h0001;
		// Setup window: ended by STOP or by the timeout, never reopened.
		if (s_q.inSetup) begin
			if (tick && !s_q.ctrl2[CTRL2_TO_DIS]) begin
				s_d.winMs = s_q.winMs + 16'h0001;
			end
			if (busStop || (s_q.winMs == 16'(WINDOW_TIMEOUT_MS))) begin
				s_d.inSetup = 1'b0;
				s_d.readyOe = 1'b0;
				startTune = !s_q.ctrl[CTRL_TDIS];
			end
		end else if (s_q.scanCnt == 16'h0000) begin
			// Sequential channel scan; fast scan drops all dead time.
			s_d.convStart = 1'b1;
			s_d.convChan = (s_q.convChan == 2'(NUM_CH - 1)) ? 2'h0 : s_q.convChan + 2'h1;
			s_d.scanCnt = s_q.ctrl[CTRL_FAST] ? 16'h0000 : 16'(SCAN_PERIOD_CYCLES - 1);
		end else begin
			s_d.scanCnt = s_q.scanCnt - 16'h0001;
		end
		// Millisecond timers: delayed reseed and retune inhibit.
		if (tick) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (s_q.reseedPend[i]) begin
					if (s_q.reseedMs[i] <= 8'h01) begin
						s_d.baseline[i] = reseedVal(s_q.baseline[i], touchThr[i], !self);
						s_d.reseedPend[i] = 1'b0;
					end else begin
						s_d.reseedMs[i] = s_q.reseedMs[i] - 8'h01;
					end
				end
				if (s_q.inhibitMs[i] != 14'h0000) begin
					s_d.inhibitMs[i] = s_q.inhibitMs[i] - 14'h0001;
				end
			end
		end
		// Per-sample decisions for the reported channel.
		if (sample.valid && !s_q.inSetup && (c < 2'(NUM_CH))) begin
			bl = s_d.baseline[c];
			thr = touchThr[c];
			if (self) begin
				tDet = ({1'b0, cnt} + {1'b0, thr}) < {1'b0, bl};
				pDet = ({1'b0, cnt} + 13'(thrClamp(s_q.proxSet[c]))) < {1'b0, bl};
			end else begin
				tDet = {1'b0, cnt} > ({1'b0, bl} + {1'b0, thr});
				pDet = {1'b0, cnt} > ({1'b0, bl} + 13'(thrClamp(s_q.proxSet[c])));
			end
			diff = (cnt > bl) ? cnt - bl : bl - cnt;
			// Slow baseline tracking, halted by proximity outside touch state.
			if (!(pDet && !s_q.touchState[c]) && (cnt != bl)) begin
				s_d.baseline[c] = (cnt > bl) ? bl + 12'h001 : bl - 12'h001;
			end
			s_d.touchBit[c] = tDet;
			s_d.proxBit[c] = pDet;
			if (!s_q.hystMask[c]) begin
				if (s_q.touchBit[c] && !tDet && !s_q.ctrl2[CTRL2_INH_DIS]) begin
					s_d.inhibitMs[c] = 14'(INHIBIT_MS);
				end
			end else if (!s_q.touchState[c]) begin
				s_d.pendTouch[c] = tDet;
				if (tDet && (s_q.ctrl[CTRL_FAST] || s_q.pendTouch[c])) begin
					s_d.touchState[c] = 1'b1;
					s_d.pendTouch[c] = 1'b0;
					s_d.entryBase[c] = bl;
					s_d.dynValid[c] = 1'b0;
					if (s_q.ctrl2[CTRL2_RSD_DIS]) begin
						s_d.baseline[c] = reseedVal(bl, thr, !self);
					end else begin
						s_d.reseedPend[c] = 1'b1;
						s_d.reseedMs[c] = 8'(RESEED_DELAY_MS);
					end
				end
			end else begin
				if (!s_d.reseedPend[c] && !s_q.dynValid[c] && (diff <= DYN_WINDOW)) begin
					s_d.dynValid[c] = 1'b1;
					s_d.dynThr[c] = (s_q.entryBase[c] > cnt) ? s_q.entryBase[c] - cnt :
						cnt - s_q.entryBase[c];
				end
				// A threshold found in this sample applies at once, so a fresh reseed cannot
				// release a channel through the small user threshold alone.
				mx = (s_d.dynValid[c] && (s_d.dynThr[c] > thr)) ? s_d.dynThr[c] : thr;
				rel = relFrac(mx, s_q.ctrl2[1:0]);
				if (self ? ({1'b0, cnt} > ({1'b0, bl} + {1'b0, rel})) :
					(({1'b0, cnt} + {1'b0, rel}) < {1'b0, bl})) begin
					s_d.touchState[c] = 1'b0;
					s_d.dynValid[c] = 1'b0;
					s_d.reseedPend[c] = 1'b0;
					if (!s_q.ctrl2[CTRL2_INH_DIS]) begin
						s_d.inhibitMs[c] = 14'(INHIBIT_MS);
					end
				end
			end
			// Tuning step for this channel.
			if (s_q.busy && !s_q.tuneDone[c]) begin
				goal = s_q.ctrl[CTRL_EXTB] ? CNT_W'({s_q.base[c], 4'h0}) :
					CNT_W'({s_q.base[c], 3'h0});
				if (!s_q.multDone[c]) begin
					if ((cnt < goal) && (s_q.mult[c] != MULT_MAX)) begin
						s_d.mult[c] = s_q.mult[c] + 4'h1;
					end else begin
						s_d.multDone[c] = 1'b1;
					end
				end else if (({1'b0, cnt} + {1'b0, TUNE_TOL}) < tgt) begin
					if (s_q.comp[c] != COMP_MAX) s_d.comp[c] = s_q.comp[c] + 6'h01;
					else s_d.tuneDone[c] = 1'b1;
				end else if ({1'b0, cnt} > (tgt + {1'b0, TUNE_TOL})) begin
					if (s_q.comp[c] != '0) s_d.comp[c] = s_q.comp[c] - 6'h01;
					else s_d.tuneDone[c] = 1'b1;
				end else begin
					s_d.tuneDone[c] = 1'b1;
				end
			end
			// Automatic retune when the count leaves the target band.
			if (!s_q.busy && !s_q.ctrl[CTRL_TDIS] && (s_q.inhibitMs[c] == 14'h0000) &&
				(({1'b0, cnt} > (tgt + (tgt >> RELIMIT_SHIFT))) ||
				(({1'b0, cnt} + (tgt >> RELIMIT_SHIFT)) < tgt))) begin
				startTune = 1'b1;
			end
		end
		if (s_q.busy && (&s_d.tuneDone)) begin
			s_d.busy = 1'b0;
		end
		// Start of a tuning event; a pending request is consumed here.
		if (s_q.ctrl[CTRL_RETUNE]) begin
			startTune = 1'b1;
			s_d.ctrl[CTRL_RETUNE] = 1'b0;
		end
		if (startTune) begin
			s_d.busy = 1'b1;
			s_d.tuneDone = '0;
			s_d.multDone = s_q.ctrl[CTRL_MGS] ? '1 : '0;
			if (!s_q.ctrl[CTRL_MGS]) s_d.mult = '0;
		end
		// Register writes come last so a host set beats the self-clear.
		if (regReq.wrEn) begin
			unique case (regReq.addr)
				ADDR_CTRL: begin
					s_d.ctrl[6:0] = regReq.wrData[6:0];
					if (s_q.inSetup) s_d.ctrl[CTRL_PROJ] = regReq.wrData[CTRL_PROJ];
				end
				ADDR_CTRL2: s_d.ctrl2 = regReq.wrData;
				ADDR_HYST_CHANS: s_d.hystMask = regReq.wrData;
				ADDR_TARGET: s_d.target = regReq.wrData;
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (regReq.addr == ADDR_BASE0 + 8'(i)) s_d.base[i] = regReq.wrData;
						if (regReq.addr == ADDR_TOUCH_SET0 + 8'(i)) s_d.touchSet[i] = regReq.wrData;
						if (regReq.addr == ADDR_PROX_SET0 + 8'(i)) s_d.proxSet[i] = regReq.wrData;
					end
				end
			endcase
		end
		// Reported outputs, with channel-1 blocking applied.
		blk = s_d.ctrl[CTRL_BLK] && (s_d.hystMask[1] ? s_d.touchState[1] : s_d.touchBit[1]);
		for (int i = 0; i < NUM_CH; i++) begin
			s_d.hystOut[i] = s_d.hystMask[i] && (s_d.touchState[i] ||
				(!s_d.ctrl[CTRL_OOT] && s_d.proxBit[i]));
			s_d.touchRep[i] = s_d.touchBit[i];
			if (blk && (i != 1)) begin
				s_d.hystOut[i] = 1'b0;
				if (!s_d.hystMask[i]) s_d.touchRep[i] = 1'b0;
			end
			s_d.multOut[i] = s_d.ctrl[CTRL_MGS] ? s_d.base[i] : 8'(s_d.mult[i]);
		end
		// Registered read data; unmapped offsets read zero.
		if (regReq.rdEn) begin
			s_d.rdData = 8'h00;
			unique case (regReq.addr)
				ADDR_SYSTEM_FLAGS: s_d.rdData = {5'h00, s_q.ctrl[CTRL_PROJ], s_q.inSetup, s_q.busy};
				ADDR_CTRL: s_d.rdData = s_q.ctrl;
				ADDR_CTRL2: s_d.rdData = s_q.ctrl2;
				ADDR_HYST_CHANS: s_d.rdData = s_q.hystMask;
				ADDR_TARGET: s_d.rdData = s_q.target;
				ADDR_HYST_OUT: s_d.rdData = 8'(s_q.hystOut);
				ADDR_HYST_TOUCH: s_d.rdData = 8'(s_q.touchState);
				ADDR_STATUS: s_d.rdData = {1'b0, s_q.proxBit, 1'b0, s_q.touchRep};
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (regReq.addr == ADDR_BASE0 + 8'(i)) s_d.rdData = s_q.base[i];
						if (regReq.addr == ADDR_TOUCH_SET0 + 8'(i)) s_d.rdData = s_q.touchSet[i];
						if (regReq.addr == ADDR_PROX_SET0 + 8'(i)) s_d.rdData = s_q.proxSet[i];
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.inSetup <= 1'b1;
			s_q.readyOe <= 1'b1;
			s_q.ctrl <= CTRL_RST;
			s_q.ctrl2 <= CTRL2_RST;
			s_q.hystMask <= HYST_RST;
			s_q.target <= TARGET_RST;
			s_q.base <= {NUM_CH{BASE_RST}};
			s_q.touchSet <= {NUM_CH{TOUCH_SET_RST}};
			s_q.proxSet <= {NUM_CH{PROX_SET_RST}};
			s_q.tuneDone <= '1;
			s_q.multDone <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign readyOut = 1'b0;
	assign readyOe = s_q.readyOe;
	assign convStart = s_q.convStart;
	assign convChan = s_q.convChan;
	assign filterBypass = s_q.ctrl[CTRL_FAST];
	assign projMode = s_q.ctrl[CTRL_PROJ];
	assign tuneBusy = s_q.busy;
	assign compOut = s_q.comp;
	assign multOut = s_q.multOut;
	assign hystOutput = s_q.hystOut;
	assign hystTouchState = s_q.touchState;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_THR_FLOOR: assert property (s_q.touchSet[0] == 8'h00 |->
		touchThr[0] == (s_q.baseline[0] >> THR_SHIFT)) else $error("Threshold floor wrong.");
	AST_TDIS_HOLDS: assert property (s_q.ctrl[CTRL_TDIS] && !s_q.busy &&
		!s_q.ctrl[CTRL_RETUNE] |=> !s_q.busy) else $error("Tuning started while disabled.");
	AST_BUSY_END: assert property ($fell(s_q.busy) |-> &s_q.tuneDone)
		else $error("Busy dropped before tuning finished.");
	AST_RETUNE_CLR: assert property (s_q.ctrl[CTRL_RETUNE] && !regReq.wrEn |=>
		s_q.busy && !s_q.ctrl[CTRL_RETUNE]) else $error("Retune request not consumed.");
	AST_SETUP_ONCE: assert property (!s_q.inSetup |=> !s_q.inSetup && !readyOe)
		else $error("Setup window reopened.");
	AST_MODE_LOCK: assert property (!s_q.inSetup && s_q.strapCnt == STRAP_DONE |=>
		$stable(projMode)) else $error("Sensing mode changed outside setup.");
	AST_BLOCK: assert property (s_q.ctrl[CTRL_BLK] && s_q.hystMask[1] && s_q.touchState[1]
		|-> !s_q.hystOut[0] && !s_q.hystOut[2]) else $error("Blocking failed.");
	AST_EXIT_CLR: assert property ($fell(s_q.touchState[0]) && s_q.ctrl[CTRL_OOT] |->
		!hystOutput[0]) else $error("Output not cleared on exit.");
	AST_INHIBIT: assert property ($fell(s_q.touchState[0]) && !s_q.ctrl2[CTRL2_INH_DIS] |->
		s_q.inhibitMs[0] == 14'(INHIBIT_MS)) else $error("Retune inhibit not started.");
	AST_RESEED: assert property ($rose(s_q.touchState[0]) && !s_q.ctrl2[CTRL2_RSD_DIS] |->
		s_q.reseedPend[0] && s_q.reseedMs[0] == 8'(RESEED_DELAY_MS)) else $error("Reseed delay bad.");
endmodule : cth_tuning_logic

// ---- verification/cth_electrode_model.sv ----
// Purpose: Behavioural electrodes that answer each conversion start with a sample.
// Assumes: The count rises 4 per compensation step and 16 per multiplier step.
// Notes: A press lowers the count of a channel by the drop the bench gives it.
`timescale 1ns/10ps
module cth_electrode_model (
	input wire logic clk,
	input wire logic convStart,
	input wire logic [1:0] convChan,
	input wire logic [cth_pkg::NUM_CH-1:0][cth_pkg::COMP_W-1:0] compOut,
	input wire logic [cth_pkg::NUM_CH-1:0][7:0] multOut,
	input wire logic [cth_pkg::NUM_CH-1:0][cth_pkg::CNT_W-1:0] drop,
	output cth_pkg::cth_sample_t sample
);
	import cth_pkg::*;
	logic [CNT_W-1:0] level;

	// Self sensing: compensation raises the count, a nearby hand lowers it.
	always_comb begin
		level = 12'h028 + {4'h0, compOut[convChan], 2'h0} + {multOut[convChan], 4'h0};
		level = level - drop[convChan];
	end

	// The sample follows its start by one cycle; idle data toggles so it is never reused.
	initial sample = '0;
	always @(posedge clk) begin
		sample.valid <= convStart;
		sample.chan <= convChan;
		sample.count <= convStart ? level : ~sample.count;
	end
endmodule : cth_electrode_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the touch tuning logic.
// Assumes: Scaled timing, a tick of 4 cycles and a 10 ms setup timeout.
// Notes: Inputs change 2 ns after the rising edge.
`timescale 1ns/10ps
module tb_top;
	import cth_pkg::*;
	logic clk, srst, busStop, factOpt;
	cth_sample_t sample;
	cth_reg_req_t regReq;
	logic [7:0] regRdData;
	logic readyOe, convStart, filterBypass, projMode, tuneBusy;
	logic [1:0] convChan;
	logic [NUM_CH-1:0][COMP_W-1:0] compOut;
	logic [NUM_CH-1:0][7:0] multOut;
	logic [NUM_CH-1:0] hystOutput, hystTouchState;
	logic [NUM_CH-1:0][CNT_W-1:0] drop;
	logic [CNT_W-1:0] cnt;
	int failures, samples_checked;

	cth_tuning_logic #(.TICK_CYCLES(4), .WINDOW_TIMEOUT_MS(10)) u_dut (.clk(clk), .srst(srst),
		.sample(sample), .regReq(regReq), .busStop(busStop), .factoryOption(factOpt),
		.regRdData(regRdData), .readyOut(), .readyOe(readyOe), .convStart(convStart),
		.convChan(convChan), .filterBypass(filterBypass), .projMode(projMode),
		.tuneBusy(tuneBusy), .compOut(compOut), .multOut(multOut),
		.hystOutput(hystOutput), .hystTouchState(hystTouchState));
	cth_electrode_model u_elec (.clk(clk), .convStart(convStart), .convChan(convChan),
		.compOut(compOut), .multOut(multOut), .drop(drop), .sample(sample));

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regReq = '{1'b1, 1'b0, a, d};
		cyc(1);
		regReq = '0;
		cyc(1);
	endtask : wr
	task automatic rdr(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		regReq = '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		chk({4'h0, regRdData & m}, {4'h0, exp});
		regReq = '0;
		cyc(1);
	endtask : rdr
	task automatic waitIdle();
		for (int i = 0; i < 20000; i++) begin
			if (tuneBusy === 1'b0) return;
			cyc(1);
		end
		failures++;
		end_sim();
	endtask : waitIdle
	task automatic end_sim();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		busStop = 1'b0;
		factOpt = 1'b0;
		regReq = '0;
		drop = '0;
		failures = 0;
		samples_checked = 0;
		cyc(8);
		srst = 1'b0;
		cyc(1);
		chk({11'h0, readyOe}, 12'h001);
		rdr(ADDR_SYSTEM_FLAGS, 8'h02);
		rdr(ADDR_CTRL, CTRL_RST);
		rdr(ADDR_TARGET, TARGET_RST);
		rdr(ADDR_HYST_CHANS, HYST_RST);
		rdr(ADDR_TOUCH_SET0, TOUCH_SET_RST);
		rdr(ADDR_BASE0, BASE_RST);
		rdr(8'hd8, 8'h00);
		$display("test reset done");
		wr(ADDR_TARGET, 8'h10);
		wr(ADDR_CTRL, 8'h10);
		chk({11'h0, readyOe}, 12'h001);
		busStop = 1'b1;
		cyc(1);
		busStop = 1'b0;
		cyc(1);
		chk({11'h0, readyOe}, 12'h000);
		chk({11'h0, tuneBusy}, 12'h001);
		chk({11'h0, filterBypass}, 12'h001);
		waitIdle();
		for (int c = 0; c < NUM_CH; c++) begin
			cnt = 12'h028 + {4'h0, compOut[c], 2'h0} + {multOut[c], 4'h0};
			chk({11'h0, cnt >= 12'h078 && cnt <= 12'h088}, 12'h001);
		end
		$display("test tuning done");
		wr(ADDR_CTRL, 8'h90);
		rdr(ADDR_CTRL, 8'h10);
		chk({11'h0, projMode}, 12'h000);
		wr(ADDR_CTRL, 8'h18);
		chk({11'h0, tuneBusy}, 12'h001);
		rdr(ADDR_CTRL, 8'h10);
		waitIdle();
		$display("test retune done");
		wr(ADDR_CTRL, 8'h11);
		cyc(2000);
		drop[0] = 12'd10;
		cyc(60);
		chk({11'h0, hystOutput[0]}, 12'h001);
		chk({11'h0, hystTouchState[0]}, 12'h000);
		wr(ADDR_CTRL, 8'h31);
		cyc(5);
		chk({11'h0, hystOutput[0]}, 12'h000);
		drop[0] = 12'd40;
		cyc(60);
		chk({11'h0, hystTouchState[0]}, 12'h001);
		chk({11'h0, hystOutput[0]}, 12'h001);
		rdr(ADDR_HYST_TOUCH, 8'h01);
		cyc(1500);
		drop[0] = 12'd0;
		cyc(60);
		chk({11'h0, hystTouchState[0]}, 12'h000);
		rdr(ADDR_HYST_OUT, 8'h00);
		$display("test touch done");
		wr(ADDR_CTRL, 8'h71);
		wr(ADDR_HYST_CHANS, 8'h03);
		drop = {NUM_CH{12'd40}};
		cyc(60);
		chk({11'h0, hystTouchState[1]}, 12'h001);
		chk({9'h0, hystOutput & 3'b101}, 12'h000);
		rdr(ADDR_STATUS, 8'h40, 8'h44);
		chk({11'h0, hystTouchState[2]}, 12'h000);
		drop = '0;
		$display("test blocking done");
		wr(ADDR_BASE0, 8'h05);
		wr(ADDR_CTRL, 8'h13);
		chk({4'h0, multOut[0]}, 12'h005);
		wr(ADDR_TOUCH_SET0, 8'h00);
		$display("test manual gain done");
		factOpt = 1'b1;
		srst = 1'b1;
		cyc(8);
		srst = 1'b0;
		cyc(1);
		chk({11'h0, readyOe}, 12'h001);
		cyc(59);
		chk({11'h0, readyOe}, 12'h000);
		chk({11'h0, projMode}, 12'h001);
		$display("test timeout done");
		end_sim();
	end
endmodule : tb_top
